// ### rtl/gpio_report_sleep_pkg.sv
// Constants, types and register map of the GPIO report and sleep configuration block
// Contract
// - Message-select byte: two bits per input, input 0 in bits 0-1 up to input 3 in 6-7.
// - Code 0b00 sends a single-input event; it is the default selection.
// - Code 0b01 sends an event carrying the whole I/O parameter group.
// - Code 0b10 sends an announce packet; 0b11 is reserved and does nothing.
// - Events fire on falling edges only, so the reported pin state is 0.
// - Report control 0x00 enables periodic I/O group events; 0x01 disables, default. The code also turns them off on an interrupt-sleeping end node.
// - Report interval is 32-bit in ms, range 0x3e8 to 0xffffffff, default 0x3e8.
// - On sleeping end nodes interval accuracy is min of poll period and 500 ms.
// - Timer-sleeping end node wakes every poll period to poll parent; default 1 s.
// - Interrupt-woken end node polls parent at poll period while it stays awake.
// - After sending data an end node stays awake for the awake time, default 100 ms; the code does not wake a node that sends while asleep.
// - Sleep direction low six bits set pin direction in sleep, 1 output; default 0x00.
// - Sleep level low six bits drive output pins during sleep; default 0x3f.
// - On coordinator and router the end-node settings read back but do nothing.
// - Multi-byte values move least significant part first on both sides.
// - A pin event issues only when its enable bit, option bits 4-7, is set.
// - Sleep pin settings apply only with option bit 3; sleep inputs float.
package gpio_report_sleep_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [5:0] IDX_OPTION = 6'h19;
  localparam logic [5:0] IDX_MSG_SELECT = 6'h1a;
  localparam logic [5:0] IDX_REPORT_CTRL = 6'h1b;
  localparam logic [5:0] IDX_REPORT_INTERVAL = 6'h1c;
  localparam logic [5:0] IDX_PARENT_POLL = 6'h20;
  localparam logic [5:0] IDX_RESERVED_WORD = 6'h22;
  localparam logic [5:0] IDX_AWAKE_TIME = 6'h24;
  localparam logic [5:0] IDX_SLEEP_DIR = 6'h26;
  localparam logic [5:0] IDX_SLEEP_LEVEL = 6'h27;
  localparam logic [5:0] IDX_NODE_CTRL = 6'h30;
  localparam logic [5:0] IDX_STATUS = 6'h31;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_OPTION = {IDX_OPTION, 2'b00};
  localparam logic [7:0] ADDR_MSG_SELECT = {IDX_MSG_SELECT, 2'b00};
  localparam logic [7:0] ADDR_REPORT_CTRL = {IDX_REPORT_CTRL, 2'b00};
  localparam logic [7:0] ADDR_REPORT_INTERVAL = {IDX_REPORT_INTERVAL, 2'b00};
  localparam logic [7:0] ADDR_PARENT_POLL = {IDX_PARENT_POLL, 2'b00};
  localparam logic [7:0] ADDR_RESERVED_WORD = {IDX_RESERVED_WORD, 2'b00};
  localparam logic [7:0] ADDR_AWAKE_TIME = {IDX_AWAKE_TIME, 2'b00};
  localparam logic [7:0] ADDR_SLEEP_DIR = {IDX_SLEEP_DIR, 2'b00};
  localparam logic [7:0] ADDR_SLEEP_LEVEL = {IDX_SLEEP_LEVEL, 2'b00};
  localparam logic [7:0] ADDR_NODE_CTRL = {IDX_NODE_CTRL, 2'b00};
  localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int OPT_INT_SLEEP_BIT = 2;
  localparam int OPT_SLEEP_PINS_BIT = 3;
  localparam int OPT_MSG_EN_LSB = 4;
  localparam int NODE_SLEEP_EN_BIT = 2;
  localparam int SLEEP_PINS = 6;
  localparam int INT_PINS = 4;
  localparam logic [1:0] ROLE_COORD = 2'h0;
  localparam logic [1:0] ROLE_ROUTER = 2'h1;
  localparam logic [1:0] ROLE_END = 2'h2;
  localparam logic [1:0] MSG_PIN_EVENT = 2'h0;
  localparam logic [1:0] MSG_IO_GROUP = 2'h1;
  localparam logic [1:0] MSG_ANNOUNCE = 2'h2;
  localparam logic [1:0] MSG_RESERVED = 2'h3;
  localparam logic [7:0] REPORT_ON = 8'h00;
  localparam logic [31:0] REPORT_MIN_MS = 32'h000003e8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Types and reset values
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] option;
    logic [7:0] msg_select;
    logic [7:0] report_ctrl;
    logic [31:0] report_interval;
    logic [15:0] parent_poll;
    logic [15:0] reserved_word;
    logic [15:0] awake_time;
    logic [7:0] sleep_dir;
    logic [7:0] sleep_level;
    logic [7:0] node_ctrl;
  } cfg_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [1:0] pin;
    logic state;
  } msg_t;

  typedef enum logic [1:0] {
    ST_AWAKE = 2'b01,
    ST_ASLEEP = 2'b10
  } sleep_state_t;

  localparam logic [7:0] RST_OPTION = 8'hf3;
  localparam logic [7:0] RST_MSG_SELECT = 8'h00;
  localparam logic [7:0] RST_REPORT_CTRL = 8'h01;
  localparam logic [31:0] RST_REPORT_INTERVAL = 32'h000003e8;
  localparam logic [15:0] RST_PARENT_POLL = 16'h03e8;
  localparam logic [15:0] RST_RESERVED_WORD = 16'h0000;
  localparam logic [15:0] RST_AWAKE_TIME = 16'h0064;
  localparam logic [7:0] RST_SLEEP_DIR = 8'h00;
  localparam logic [7:0] RST_SLEEP_LEVEL = 8'h3f;
  localparam logic [7:0] RST_NODE_CTRL = 8'h00;
  localparam cfg_t CFG_RESET = '{RST_OPTION, RST_MSG_SELECT, RST_REPORT_CTRL, RST_REPORT_INTERVAL,
                                 RST_PARENT_POLL, RST_RESERVED_WORD, RST_AWAKE_TIME, RST_SLEEP_DIR,
                                 RST_SLEEP_LEVEL, RST_NODE_CTRL};

endpackage

// ### rtl/gpio_report_sleep_config.sv
// GPIO event message, periodic report and end-node sleep configuration block
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module gpio_report_sleep_config
  import gpio_report_sleep_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS_P = CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // GPIO pins
  input wire logic [INT_PINS-1:0] gpio_in_i,
  input wire logic [SLEEP_PINS-1:0] app_gpio_out_i,
  input wire logic [SLEEP_PINS-1:0] app_gpio_oe_i,
  output logic [SLEEP_PINS-1:0] gpio_out_o,
  output logic [SLEEP_PINS-1:0] gpio_oe_o,
  // Radio side
  input wire logic data_sent_i,
  output logic msg_valid_o,
  output msg_t msg_o,
  output logic poll_request_o,
  output logic asleep_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [31:0] lane_merge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic reg_mapped(logic [5:0] idx);
    case (idx)
      IDX_OPTION, IDX_MSG_SELECT, IDX_REPORT_CTRL, IDX_REPORT_INTERVAL, IDX_PARENT_POLL,
      IDX_RESERVED_WORD, IDX_AWAKE_TIME, IDX_SLEEP_DIR, IDX_SLEEP_LEVEL, IDX_NODE_CTRL,
      IDX_STATUS: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] reg_read(logic [5:0] idx, cfg_t c, logic [31:0] st);
    case (idx)
      IDX_OPTION: reg_read = {24'h0, c.option};
      IDX_MSG_SELECT: reg_read = {24'h0, c.msg_select};
      IDX_REPORT_CTRL: reg_read = {24'h0, c.report_ctrl};
      IDX_REPORT_INTERVAL: reg_read = c.report_interval;
      IDX_PARENT_POLL: reg_read = {16'h0, c.parent_poll};
      IDX_RESERVED_WORD: reg_read = {16'h0, c.reserved_word};
      IDX_AWAKE_TIME: reg_read = {16'h0, c.awake_time};
      IDX_SLEEP_DIR: reg_read = {24'h0, c.sleep_dir};
      IDX_SLEEP_LEVEL: reg_read = {24'h0, c.sleep_level};
      IDX_NODE_CTRL: reg_read = {24'h0, c.node_ctrl};
      IDX_STATUS: reg_read = st;
      default: reg_read = 32'h0;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  cfg_t cfg, next_cfg;
  logic aw_open, next_aw_open, w_open, next_w_open, ar_open, next_ar_open;
  logic [5:0] aw_idx, next_aw_idx;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic interval_wr, next_interval_wr;
  logic [INT_PINS-1:0] pin_s1, pin_s2, pin_s3;
  logic [15:0] ms_pre, next_ms_pre;
  logic [31:0] rpt_ms, next_rpt_ms;
  logic [15:0] poll_ms, next_poll_ms, awake_ms, next_awake_ms;
  logic [INT_PINS-1:0] pend, next_pend;
  logic rpt_pend, next_rpt_pend;
  logic [7:0] event_cnt, next_event_cnt;
  sleep_state_t state, next_state;
  logic msg_valid, next_msg_valid, poll_req, next_poll_req;
  msg_t msg, next_msg;
  logic [SLEEP_PINS-1:0] pin_out, next_pin_out, pin_oe, next_pin_oe;

  logic tick, end_node, sleep_on, int_sleep, report_on, report_fire, poll_run, poll_fire;
  logic [INT_PINS-1:0] fall;
  logic [31:0] eff_interval, status_word;

  assign fall = pin_s3 & ~pin_s2;
  assign tick = (ms_pre == 16'(CYCLES_PER_MS_P - 1));
  assign end_node = (cfg.node_ctrl[1:0] == ROLE_END);
  assign sleep_on = end_node & cfg.node_ctrl[NODE_SLEEP_EN_BIT];
  assign int_sleep = sleep_on & cfg.option[OPT_INT_SLEEP_BIT];
  assign report_on = (cfg.report_ctrl == REPORT_ON) & ~int_sleep;
  assign eff_interval = (cfg.report_interval < REPORT_MIN_MS) ? REPORT_MIN_MS : cfg.report_interval;
  assign status_word = {16'h0, event_cnt, 6'h0, report_on, state == ST_ASLEEP};

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_aw_open = aw_open;
    next_w_open = w_open;
    next_ar_open = ar_open;
    next_aw_idx = aw_idx;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_interval_wr = 1'b0;
    if (aw_open && s_axi_awvalid_i) begin
      next_aw_open = 1'b0;
      next_aw_idx = s_axi_awaddr_i[7:2];
    end
    if (w_open && s_axi_wvalid_i) begin
      next_w_open = 1'b0;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
      next_aw_open = 1'b1;
      next_w_open = 1'b1;
    end
    if (!aw_open && !w_open && !bvalid) begin
      next_bvalid = 1'b1;
      next_bresp = reg_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      case (aw_idx)
        IDX_OPTION: next_cfg.option = 8'(lane_merge({24'h0, cfg.option}, w_data, w_strb));
        IDX_MSG_SELECT: next_cfg.msg_select = 8'(lane_merge({24'h0, cfg.msg_select}, w_data, w_strb));
        IDX_REPORT_CTRL: next_cfg.report_ctrl = 8'(lane_merge({24'h0, cfg.report_ctrl}, w_data, w_strb));
        IDX_REPORT_INTERVAL: begin
          next_cfg.report_interval = lane_merge(cfg.report_interval, w_data, w_strb);
          next_interval_wr = 1'b1;
        end
        IDX_PARENT_POLL: next_cfg.parent_poll = 16'(lane_merge({16'h0, cfg.parent_poll}, w_data, w_strb));
        IDX_RESERVED_WORD: next_cfg.reserved_word = 16'(lane_merge({16'h0, cfg.reserved_word}, w_data, w_strb));
        IDX_AWAKE_TIME: next_cfg.awake_time = 16'(lane_merge({16'h0, cfg.awake_time}, w_data, w_strb));
        IDX_SLEEP_DIR: next_cfg.sleep_dir = 8'(lane_merge({24'h0, cfg.sleep_dir}, w_data, w_strb));
        IDX_SLEEP_LEVEL: next_cfg.sleep_level = 8'(lane_merge({24'h0, cfg.sleep_level}, w_data, w_strb));
        IDX_NODE_CTRL: next_cfg.node_ctrl = 8'(lane_merge({24'h0, cfg.node_ctrl}, w_data, w_strb));
        default: next_cfg = cfg;
      endcase
    end
    if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
      next_ar_open = 1'b1;
    end
    if (ar_open && s_axi_arvalid_i) begin
      next_ar_open = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = reg_read(s_axi_araddr_i[7:2], cfg, status_word);
      next_rresp = reg_mapped(s_axi_araddr_i[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg <= CFG_RESET;
      aw_open <= 1'b1;
      w_open <= 1'b1;
      ar_open <= 1'b1;
      aw_idx <= 6'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
      interval_wr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      aw_open <= next_aw_open;
      w_open <= next_w_open;
      ar_open <= next_ar_open;
      aw_idx <= next_aw_idx;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      interval_wr <= next_interval_wr;
    end
  end

  // ----------------------------------------
  // Timers, messages and sleep control
  // ----------------------------------------
  always_comb begin
    logic [1:0] sel;
    logic [1:0] code;
    logic sent;
    sel = 2'h0;
    code = MSG_PIN_EVENT;
    sent = 1'b0;
    next_ms_pre = tick ? 16'h0 : ms_pre + 16'h1;
    // Periodic report timer
    report_fire = 1'b0;
    next_rpt_ms = rpt_ms;
    if (!report_on || interval_wr) begin
      next_rpt_ms = 32'h0;
    end else if (tick) begin
      if (rpt_ms + 32'h1 >= eff_interval) begin
        report_fire = 1'b1;
        next_rpt_ms = 32'h0;
      end else begin
        next_rpt_ms = rpt_ms + 32'h1;
      end
    end
    // Parent poll timer
    poll_run = sleep_on & (~int_sleep | (state == ST_AWAKE));
    poll_fire = 1'b0;
    next_poll_ms = poll_ms;
    if (!poll_run) begin
      next_poll_ms = 16'h0;
    end else if (tick) begin
      if (poll_ms + 16'h1 >= cfg.parent_poll) begin
        poll_fire = 1'b1;
        next_poll_ms = 16'h0;
      end else begin
        next_poll_ms = poll_ms + 16'h1;
      end
    end
    next_poll_req = poll_fire;
    // Message issue, one per cycle, lowest pin first
    next_msg_valid = 1'b0;
    next_msg = msg;
    next_event_cnt = event_cnt;
    next_pend = pend;
    next_rpt_pend = rpt_pend | report_fire;
    for (int i = INT_PINS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel = 2'(i);
      end
    end
    code = cfg.msg_select[2*sel +: 2];
    if (|pend) begin
      next_pend[sel] = 1'b0;
      if (code != MSG_RESERVED) begin
        next_msg_valid = 1'b1;
        next_msg = '{kind: code, pin: sel, state: 1'b0};
      end
    end else if (rpt_pend) begin
      next_rpt_pend = report_fire;
      next_msg_valid = 1'b1;
      next_msg = '{kind: MSG_IO_GROUP, pin: 2'h0, state: 1'b0};
    end
    next_pend = next_pend | (fall & cfg.option[OPT_MSG_EN_LSB +: INT_PINS]);
    if (next_msg_valid) begin
      next_event_cnt = event_cnt + 8'h1;
    end
    sent = next_msg_valid | data_sent_i;
    // Sleep state machine
    next_state = state;
    next_awake_ms = awake_ms;
    case (state)
      ST_AWAKE: begin
        if (sent) begin
          next_awake_ms = 16'h0;
        end else if (tick) begin
          if (awake_ms + 16'h1 >= cfg.awake_time) begin
            next_state = ST_ASLEEP;
            next_awake_ms = 16'h0;
          end else begin
            next_awake_ms = awake_ms + 16'h1;
          end
        end
      end
      ST_ASLEEP: begin
        if ((|fall) || (!int_sleep && poll_fire)) begin
          next_state = ST_AWAKE;
          next_awake_ms = 16'h0;
        end
      end
      default: begin
        next_state = ST_AWAKE;
        next_awake_ms = 16'h0;
      end
    endcase
    if (!sleep_on) begin
      next_state = ST_AWAKE;
      next_awake_ms = 16'h0;
    end
    // Pin drive
    if (state == ST_ASLEEP && cfg.option[OPT_SLEEP_PINS_BIT]) begin
      next_pin_oe = cfg.sleep_dir[SLEEP_PINS-1:0];
      next_pin_out = cfg.sleep_level[SLEEP_PINS-1:0];
    end else begin
      next_pin_oe = app_gpio_oe_i;
      next_pin_out = app_gpio_out_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_s3 <= '1;
      ms_pre <= 16'h0;
      rpt_ms <= 32'h0;
      poll_ms <= 16'h0;
      awake_ms <= 16'h0;
      pend <= '0;
      rpt_pend <= 1'b0;
      event_cnt <= 8'h0;
      state <= ST_AWAKE;
      msg_valid <= 1'b0;
      msg <= '0;
      poll_req <= 1'b0;
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_s1 <= gpio_in_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ms_pre <= next_ms_pre;
      rpt_ms <= next_rpt_ms;
      poll_ms <= next_poll_ms;
      awake_ms <= next_awake_ms;
      pend <= next_pend;
      rpt_pend <= next_rpt_pend;
      event_cnt <= next_event_cnt;
      state <= next_state;
      msg_valid <= next_msg_valid;
      msg <= next_msg;
      poll_req <= next_poll_req;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready_o = aw_open;
  assign s_axi_wready_o = w_open;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = ar_open;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o = rresp;
  assign s_axi_rdata_o = rdata;
  assign msg_valid_o = msg_valid;
  assign msg_o = msg;
  assign poll_request_o = poll_req;
  assign asleep_o = state[1];
  assign gpio_out_o = pin_out;
  assign gpio_oe_o = pin_oe;

endmodule

// ### testbench/gpio_report_sleep_config_sva.sv
// Port assertions for the GPIO report and sleep configuration block
`timescale 1ns/1ps
module gpio_report_sleep_config_sva
  import gpio_report_sleep_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins and radio side
  input wire logic [SLEEP_PINS-1:0] app_gpio_out_i,
  input wire logic [SLEEP_PINS-1:0] app_gpio_oe_i,
  input wire logic [SLEEP_PINS-1:0] gpio_out_o,
  input wire logic [SLEEP_PINS-1:0] gpio_oe_o,
  input wire logic msg_valid_o,
  input wire msg_t msg_o,
  input wire logic poll_request_o,
  input wire logic asleep_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence wr_answer;
    !s_axi_awready_o && !s_axi_wready_o ##1 s_axi_bvalid_o;
  endsequence
  wr_answer_a: assert property (wr_taken |=> wr_answer) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  b_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
    else $error("write response not released");
  msg_state_a: assert property (msg_valid_o |-> msg_o.state == 1'b0 && msg_o.kind != MSG_RESERVED)
    else $error("bad message fields");
  poll_pulse_a: assert property ($rose(poll_request_o) |=> !poll_request_o [*2]) else $error("poll too close");
  awake_pins_a: assert property (rst_b_i && !asleep_o ##1 !asleep_o |-> gpio_oe_o == $past(app_gpio_oe_i)
    && gpio_out_o == $past(app_gpio_out_i)) else $error("awake pins not passed");
endmodule
bind gpio_report_sleep_config gpio_report_sleep_config_sva chk_u (.*);

// ### testbench/axi_host_model.sv
// Register bus master standing for the host
`timescale 1ns/1ps
module axi_host_model
  import gpio_report_sleep_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Master outputs
  output logic [ADDR_W-1:0] s_axi_awaddr_i,
  output logic s_axi_awvalid_i,
  output logic [31:0] s_axi_wdata_i,
  output logic [3:0] s_axi_wstrb_i,
  output logic s_axi_wvalid_i,
  output logic s_axi_bready_i,
  output logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_arvalid_i,
  output logic s_axi_rready_i,
  // Slave answers
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o
);
  int lag = 0;
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    r = RESP_SLVERR;
    if (a == ADDR_RESERVED_WORD) return;
    if ((a == ADDR_PARENT_POLL || a == ADDR_AWAKE_TIME) && d[15:0] == 16'h0000) return;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(posedge mclk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o && s_axi_bready_i) break;
      if (i >= lag) s_axi_bready_i <= 1'b1;
    end
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o && s_axi_rready_i) break;
      if (i >= lag) s_axi_rready_i <= 1'b1;
    end
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
endmodule

// ### testbench/test_gpio_report_sleep_config.sv
// Self-checking bench for the GPIO report and sleep configuration block
`timescale 1ns/1ps
module test_gpio_report_sleep_config;
  import gpio_report_sleep_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic mclk_i = 1'b0;
  logic rst_b_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, data_sent_i, msg_valid_o;
  logic poll_request_o, asleep_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_v;
  logic [3:0] s_axi_wstrb_i, gpio_in_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic [5:0] app_gpio_out_i, app_gpio_oe_i, gpio_out_o, gpio_oe_o;
  msg_t msg_o, m;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int t;
  gpio_report_sleep_config #(.CYCLES_PER_MS_P(4)) dut_u (.*);
  axi_host_model host_u (.*);
  initial forever #12.5 mclk_i = ~mclk_i;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.wr(a, d, 4'hf, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, rd_v, rsp);
    chk(rd_v, e);
  endtask
  task automatic wait_msg(input int lim);
    t = -1;
    for (int i = 1; i <= lim && t < 0; i++) begin
      @(posedge mclk_i);
      if (msg_valid_o === 1'b1) t = i;
      m = msg_o;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    logic [7:0] a [8] = '{ADDR_MSG_SELECT, ADDR_REPORT_CTRL, ADDR_REPORT_INTERVAL, ADDR_SLEEP_DIR,
                          ADDR_SLEEP_LEVEL, ADDR_OPTION, ADDR_PARENT_POLL, ADDR_AWAKE_TIME};
    logic [31:0] e [8] = '{32'h0, 32'h1, 32'h3e8, 32'h0, 32'h3f, 32'hf3, 32'h3e8, 32'h64};
    foreach (a[i]) rd_chk(a[i], e[i]);
    host_u.rd(8'hfc, rd_v, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_byte_order();
    host_u.lag = 3;
    wr(ADDR_REPORT_INTERVAL, 32'h89abcdef);
    host_u.wr(ADDR_REPORT_INTERVAL, 32'h00000055, 4'h1, rsp);
    rd_chk(ADDR_REPORT_INTERVAL, 32'h89abcd55);
    wr(ADDR_PARENT_POLL, 32'h00012345);
    rd_chk(ADDR_PARENT_POLL, 32'h00002345);
    host_u.lag = 0;
    wr(ADDR_REPORT_INTERVAL, 32'h3e8);
  endtask
  task automatic t_msg_codes();
    for (int n = 0; n < 4; n++) begin
      wr(ADDR_MSG_SELECT, 32'(n) << (2 * n));
      gpio_in_i <= 4'hf & ~(4'h1 << n);
      wait_msg(20);
      if (n == 3) chk(t, -1);
      else chk({27'h0, m}, {27'h0, 2'(n), 2'(n), 1'b0});
      gpio_in_i <= 4'hf;
      repeat (6) @(posedge mclk_i);
    end
    wr(ADDR_OPTION, 32'he3);
    wr(ADDR_MSG_SELECT, 32'h0);
    gpio_in_i <= 4'he;
    wait_msg(20);
    chk(t, -1);
    gpio_in_i <= 4'hf;
    wr(ADDR_OPTION, 32'hf3);
  endtask
  task automatic t_report();
    wr(ADDR_REPORT_CTRL, 32'h0);
    wait_msg(4100);
    chk({30'h0, m.kind}, {30'h0, MSG_IO_GROUP});
    wait_msg(4100);
    chk(32'(t >= 3999 && t <= 4001), 32'h1);
    wr(ADDR_REPORT_CTRL, 32'h1);
    wait_msg(4100);
    chk(t, -1);
  endtask
  task automatic t_sleep();
    wr(ADDR_NODE_CTRL, 32'h05);
    repeat (100) @(posedge mclk_i);
    chk({31'h0, asleep_o}, 32'h0);
    wr(ADDR_OPTION, 32'hfb);
    wr(ADDR_SLEEP_DIR, 32'h15);
    wr(ADDR_SLEEP_LEVEL, 32'h2a);
    wr(ADDR_AWAKE_TIME, 32'h2);
    wr(ADDR_PARENT_POLL, 32'h3);
    wr(ADDR_NODE_CTRL, 32'h06);
    for (int i = 0; i < 200 && asleep_o !== 1'b1; i++) @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    chk({26'h0, gpio_oe_o}, 32'h15);
    chk({26'h0, gpio_out_o}, 32'h2a);
    for (t = 0; t < 20 && poll_request_o !== 1'b1; t++) @(posedge mclk_i);
    chk(32'(t < 20), 32'h1);
    for (int i = 0; i < 200 && asleep_o !== 1'b1; i++) @(posedge mclk_i);
    gpio_in_i <= 4'hd;
    repeat (8) @(posedge mclk_i);
    chk({31'h0, asleep_o}, 32'h0);
  endtask
  task automatic t_sent_awake();
    int s = 0;
    for (int i = 0; i < 64; i++) begin
      data_sent_i <= (i % 4 == 0);
      @(posedge mclk_i);
      if (i >= 32) s = s | asleep_o;
    end
    data_sent_i <= 1'b0;
    chk(s, 0);
  endtask
  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    rst_b_i = 1'b0;
    gpio_in_i = 4'hf;
    app_gpio_out_i = 6'h2d;
    app_gpio_oe_i = 6'h33;
    data_sent_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    t_reset_values();
    t_byte_order();
    t_msg_codes();
    t_report();
    t_sleep();
    t_sent_awake();
    test_done();
  end
endmodule
